// File: hdl/lblu_pkg.sv
// Purpose: shared types and constants of the ladder bit logic unit
// Assumes: one controller clock, device bit memory outside the unit
// Notes:   edge storage is sized for the larger controller variant
package lblu_pkg;

    // previous-scan slots, larger variant
    localparam int EDGE_SLOTS_LARGE = 2048;
    // previous-scan slots, smaller variant
    localparam int EDGE_SLOTS_SMALL = 512;
    localparam int SLOT_W           = 11;

    localparam logic [SLOT_W-1:0] SMALL_LIMIT = 11'h0200;
    localparam logic [EDGE_SLOTS_LARGE-1:0] PREV_RESET = '0;
    localparam logic [1:0] RST_SYNC_RESET = 2'h0;

    typedef enum logic [2:0] {
        LBLU_OP_NO_CONTACT = 3'b000,
        LBLU_OP_NC_CONTACT = 3'b001,
        LBLU_OP_RISE       = 3'b010,
        LBLU_OP_FALL       = 3'b011,
        LBLU_OP_COIL       = 3'b100,
        LBLU_OP_FORCED     = 3'b101,
        LBLU_OP_INVERTER   = 3'b110,
        LBLU_OP_INV_COIL   = 3'b111
    } lblu_op_e;

    typedef struct packed {
        logic              valid;
        lblu_op_e          op;
        logic              rung_in;
        logic              dev_bit;
        logic [SLOT_W-1:0] slot;
    } lblu_req_s;

    typedef struct packed {
        logic valid;
        logic rung_out;
        logic wr_en;
        logic wr_bit;
        logic slot_err;
    } lblu_res_s;

    localparam lblu_res_s RES_RESET = '0;

    typedef struct packed {
        lblu_res_s                   res;
        logic [EDGE_SLOTS_LARGE-1:0] prev;
    } lblu_state_s;

endpackage

// File: hdl/lblu_unit.sv
// Purpose: evaluates one bit-level ladder element per request
// Assumes: sequencer supplies rung input and the operand bit it read
// Notes:   result appears one clock after the request, from flip-flops
//          slot_err flags a rise or fall slot beyond the small store, in the small variant only
//          the store is sized for the large variant in either mode:
//          one build serves both controllers at the cost of idle flops
//          a slot used twice in one scan sees its own last write
//          the sequencer must hold off requests while reset settles
//
// Summary of operation
// RQ1: NC contact output ON only when rung ON and device bit OFF.
// RQ2: rising contact ON one scan when rung was OFF, now ON.
// RQ3: falling contact ON one scan when rung was ON, now OFF.
// RQ4: small variant keeps previous-scan state for up to 512 edge slots.
// RQ5: large variant keeps previous-scan state for up to 2048 edge slots.
// RQ6: coil writes device bit equal to rung input, no rung output.
// RQ7: forced coil never writes its device bit.
// RQ8: programming tool writes forced bits directly into device memory.
// RQ9: inverter output is complement of its rung input.
// RQ10: invert coil writes complement of rung input into device bit.
// RQ11: NO contact output ON only when rung ON and device bit ON.
// RQ12: reset clears all previous-scan states to OFF.
`timescale 1ns/1ps
module lblu_unit
    import lblu_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire logic      small_variant,
    input  wire lblu_req_s req,
    output lblu_res_s      res
);

    // two-stage retiming of the reset release
    logic [1:0]  rst_sync;
    logic        rst_n_int;
    // prev holds one bit per edge slot, packed into the state
    lblu_state_s state;
    lblu_state_s next_state;

    // rstn may rise at any time; retiming its release to clk keeps
    // every state flop of the unit leaving reset on the same edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_sync <= RST_SYNC_RESET;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // only the second flop drives the internal reset net
    assign rst_n_int = rst_sync[1];

    always_comb
    begin
        logic              prev_bit;
        logic              slot_ok;
        logic              rung;
        logic              bit_on;
        logic              rise_hit;
        logic              fall_hit;
        logic [SLOT_W-1:0] slot;

        prev_bit   = 1'b0;
        slot_ok    = 1'b0;
        rung       = 1'b0;
        bit_on     = 1'b0;
        rise_hit   = 1'b0;
        fall_hit   = 1'b0;
        slot       = '0;
        next_state = state;
        // answer lasts one cycle unless another request follows
        next_state.res = RES_RESET;

        rung     = req.rung_in;
        bit_on   = req.dev_bit;
        slot     = req.slot;
        // slot is read for every op, but only rise and fall use it
        prev_bit = state.prev[slot];
        // edge seen on the rung input against the previous scan
        rise_hit = rung & ~prev_bit; // RQ2
        fall_hit = ~rung & prev_bit; // RQ3

        // small variant refuses slots beyond its edge storage
        if (small_variant)
        begin
            slot_ok = (slot < SMALL_LIMIT); // RQ4
        end
        else
        begin
            // every 11-bit index lands inside the larger store
            slot_ok = 1'b1; // RQ5
        end

        if (req.valid)
        begin
            next_state.res.valid = 1'b1;
            // contacts answer on rung_out, coils other than the forced coil with a device write
            case (req.op)
                LBLU_OP_NO_CONTACT:
                begin
                    next_state.res.rung_out = rung & bit_on; // RQ11
                    next_state.res.wr_en    = 1'b0;
                    next_state.res.wr_bit   = 1'b0;
                    next_state.res.slot_err = 1'b0;
                end

                LBLU_OP_NC_CONTACT:
                begin
                    next_state.res.rung_out = rung & ~bit_on; // RQ1
                    next_state.res.wr_en    = 1'b0;
                    next_state.res.wr_bit   = 1'b0;
                    next_state.res.slot_err = 1'b0;
                end

                LBLU_OP_RISE:
                begin
                    next_state.res.wr_en  = 1'b0;
                    next_state.res.wr_bit = 1'b0;
                    if (slot_ok)
                    begin
                        next_state.res.rung_out = rise_hit; // RQ2
                        next_state.res.slot_err = 1'b0;
                        next_state.prev[slot]   = rung; // RQ2
                    end
                    else
                    begin
                        // refused: stored state left untouched
                        next_state.res.rung_out = 1'b0; // RQ4
                        next_state.res.slot_err = 1'b1; // RQ4
                    end
                end

                LBLU_OP_FALL:
                begin
                    next_state.res.wr_en  = 1'b0;
                    next_state.res.wr_bit = 1'b0;
                    if (slot_ok)
                    begin
                        next_state.res.rung_out = fall_hit; // RQ3
                        next_state.res.slot_err = 1'b0;
                        next_state.prev[slot]   = rung; // RQ3
                    end
                    else
                    begin
                        // refused: stored state left untouched
                        next_state.res.rung_out = 1'b0; // RQ4
                        next_state.res.slot_err = 1'b1; // RQ4
                    end
                end

                LBLU_OP_COIL:
                begin
                    // a coil drives no rung output of its own
                    next_state.res.rung_out = 1'b0; // RQ6
                    next_state.res.wr_en    = 1'b1; // RQ6
                    next_state.res.wr_bit   = rung; // RQ6
                    next_state.res.slot_err = 1'b0;
                end

                LBLU_OP_FORCED:
                begin
                    // no write, so a tool-forced value survives the scan
                    next_state.res.rung_out = 1'b0;
                    next_state.res.wr_en    = 1'b0; // RQ7
                    next_state.res.wr_bit   = 1'b0;
                    next_state.res.slot_err = 1'b0;
                end

                LBLU_OP_INVERTER:
                begin
                    next_state.res.rung_out = ~rung; // RQ9
                    next_state.res.wr_en    = 1'b0;
                    next_state.res.wr_bit   = 1'b0;
                    next_state.res.slot_err = 1'b0;
                end

                LBLU_OP_INV_COIL:
                begin
                    next_state.res.rung_out = 1'b0;
                    next_state.res.wr_en    = 1'b1; // RQ10
                    next_state.res.wr_bit   = ~rung; // RQ10
                    next_state.res.slot_err = 1'b0;
                end

                default:
                begin
                    // all codes decode; this only catches unknown op bits
                    next_state.res = RES_RESET;
                end
            endcase
        end
        else
        begin
            // idle cycle: store holds, answer stays cleared
            next_state.res = RES_RESET;
        end
    end

    // one register stage: the answer always lands one cycle after
    // the request, straight from flops
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            state.res  <= RES_RESET;
            state.prev <= PREV_RESET; // RQ12
        end
        else
        begin
            state <= next_state;
        end
    end

    // no logic between the state flops and the answer port
    assign res = state.res;

endmodule

// File: verification/lblu_properties.sv
// Purpose: port assertions for the ladder bit logic unit
// Assumes: requests start after internal reset release
// Notes:   one clock domain
`timescale 1ns/1ps
module lblu_chk
    import lblu_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire logic      small_variant,
    input  wire lblu_req_s req,
    input  wire lblu_res_s res
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_NC: assert property (req.valid && req.op == LBLU_OP_NC_CONTACT
        |=> res.rung_out == $past(req.rung_in & ~req.dev_bit))
        else $error("nc");
    AST_NO: assert property (req.valid && req.op == LBLU_OP_NO_CONTACT
        |=> res.rung_out == $past(req.rung_in & req.dev_bit)) else $error("no");
    AST_COIL: assert property (req.valid && req.op == LBLU_OP_COIL
        |=> res.wr_en && !res.rung_out && res.wr_bit == $past(req.rung_in))
        else $error("coil");
    AST_FORCED: assert property (req.valid && req.op == LBLU_OP_FORCED
        |=> res.valid && !res.wr_en) else $error("forced");
    AST_INV: assert property (req.valid && req.op == LBLU_OP_INVERTER
        |=> res.rung_out != $past(req.rung_in)) else $error("inverter");
    AST_INV_COIL: assert property (req.valid
        && req.op == LBLU_OP_INV_COIL |=> res.wr_en && !res.rung_out
        && res.wr_bit != $past(req.rung_in)) else $error("icoil");
    AST_EDGE_OFF: assert property (req.valid && req.op[2:1] == 2'h1
        && req.rung_in == req.op[0] |=> !res.rung_out) else $error("edge");
    AST_SMALL: assert property (req.valid && small_variant
        && req.op[2:1] == 2'h1 && req.slot >= SMALL_LIMIT
        |=> res.slot_err && !res.rung_out) else $error("small");
    AST_NOWRITE: assert property (req.valid
        && (!req.op[2] || req.op == LBLU_OP_INVERTER)
        |=> res.valid && !res.wr_en) else $error("contact wrote");
    AST_LARGE: assert property (req.valid && !small_variant
        && req.op[2:1] == 2'h1 |=> res.valid && !res.slot_err)
        else $error("large");
    AST_IDLE: assert property (!$past(req.valid) |-> res == '0)
        else $error("idle");
endmodule
bind lblu_unit lblu_chk u_chk (.clk(clk), .rstn(rstn),
    .small_variant(small_variant), .req(req), .res(res));

// File: verification/lblu_mem.sv
// Purpose: device bit memory beside the unit
// Assumes: one operand bit is enough for the scenarios
// Notes:   tool writes stand for the forced-coil debug path
`timescale 1ns/1ps
module lblu_mem
    import lblu_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      tool_wr,
    input  wire logic      tool_bit,
    input  wire lblu_res_s res,
    output logic           dev_bit
);
    always_ff @(posedge clk)
        if (tool_wr)
            dev_bit <= tool_bit;
        else if (res.wr_en)
            dev_bit <= res.wr_bit;
endmodule

// File: verification/tb.sv
// Purpose: self-checking bench for the ladder bit logic unit
// Assumes: inputs change 1 ns after the rising edge
// Notes:   answer sampled while it stands
`timescale 1ns/1ps
module tb;
    import lblu_pkg::*;
    logic      clk = 0, rstn = 0, small_variant = 0;
    logic      tool_wr = 0, tool_bit = 0;
    logic      dev_bit;
    lblu_req_s req = '0;
    lblu_res_s res;
    int        n_mismatch = 0, n_compared = 0;
    always #25 clk = ~clk;
    lblu_unit u_dut (.clk(clk), .rstn(rstn), .small_variant(small_variant),
        .req(req), .res(res));
    lblu_mem u_mem (.clk(clk), .tool_wr(tool_wr), .tool_bit(tool_bit),
        .res(res), .dev_bit(dev_bit));
    task automatic chk(input string nm, input logic [4:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic run(input lblu_op_e op, input logic r,
        input logic [SLOT_W-1:0] s, input logic [4:0] exp);
        @(posedge clk) #1 req = '{1'b1, op, r, dev_bit, s};
        @(posedge clk) #1 req.valid = 0;
        chk(op.name(), res, exp);
    endtask
    task automatic tool(input logic b);
        @(posedge clk) #1 {tool_wr, tool_bit} = {1'b1, b};
        @(posedge clk) #1 tool_wr = 0;
        chk("tool", {4'h0, dev_bit}, {4'h0, b});
    endtask
    task automatic t_contacts;
        for (int d = 0; d < 2; d++)
        begin
            tool(d[0]);
            for (int r = 0; r < 2; r++)
            begin
                run(LBLU_OP_NO_CONTACT, r[0], 0,
                    {1'b1, r[0] & d[0], 3'h0});
                run(LBLU_OP_NC_CONTACT, r[0], 0,
                    {1'b1, r[0] & ~d[0], 3'h0});
                run(LBLU_OP_INVERTER, r[0], 0,
                    {1'b1, ~r[0], 3'h0});
            end
        end
    endtask
    task automatic t_edges;
        run(LBLU_OP_RISE, 1, 11'h0005, 5'h18);
        run(LBLU_OP_RISE, 1, 11'h0005, 5'h10);
        run(LBLU_OP_FALL, 1, 11'h0007, 5'h10);
        run(LBLU_OP_FALL, 0, 11'h0007, 5'h18);
        run(LBLU_OP_FALL, 0, 11'h0007, 5'h10);
    endtask
    task automatic t_reset;
        @(posedge clk) #1 rstn = 0;
        @(posedge clk) #1 rstn = 1;
        repeat (3) @(posedge clk);
        #1 chk("reset_res", res, 5'h00);
        run(LBLU_OP_RISE, 1, 11'h0005, 5'h18);
    endtask
    task automatic t_coils;
        tool(0);
        run(LBLU_OP_FORCED, 1, 0, 5'h10);
        @(posedge clk) #1 chk("forced_keep", {4'h0, dev_bit}, 5'h00);
        tool(1);
        run(LBLU_OP_FORCED, 0, 0, 5'h10);
        @(posedge clk) #1 chk("forced_tool", {4'h0, dev_bit}, 5'h01);
        run(LBLU_OP_COIL, 0, 0, 5'h14);
        @(posedge clk) #1 chk("coil_write", {4'h0, dev_bit}, 5'h00);
        run(LBLU_OP_COIL, 1, 0, 5'h16);
        run(LBLU_OP_INV_COIL, 1, 0, 5'h14);
        run(LBLU_OP_INV_COIL, 0, 0, 5'h16);
    endtask
    task automatic t_variants;
        small_variant = 1;
        run(LBLU_OP_RISE, 1, 11'h0200, 5'h11);
        run(LBLU_OP_RISE, 1, 11'h01ff, 5'h18);
        small_variant = 0;
        run(LBLU_OP_RISE, 1, 11'h0200, 5'h18);
        run(LBLU_OP_RISE, 1, 11'h07ff, 5'h18);
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #20000 n_mismatch++;
        print_verdict();
    end
    initial
    begin
        #76 rstn = 1;
        repeat (4) @(posedge clk);
        t_contacts();
        t_edges();
        t_reset();
        t_coils();
        t_variants();
        print_verdict();
    end
endmodule
